// *** include/ltdo_pkg.sv ***
// Package for the link training debug observation slice
package ltdo_pkg;
  // ************************************************************
  // Field positions inside the 48-bit slice (bit 320 = slice bit 0)
  // ************************************************************
  localparam int unsigned LTDO_W = 48;
  localparam int unsigned STATE_LSB = 0;
  localparam int unsigned RXLP_LSB = 5;
  localparam int unsigned TXLP_LSB = 7;
  localparam int unsigned TMO_BIT = 10;
  localparam int unsigned EXIT_BIT = 11;
  localparam int unsigned ACK_BIT = 12;
  localparam int unsigned PTYPE_LSB = 13;
  localparam int unsigned DET_LSB = 16;
  localparam int unsigned PAD_LSB = 24;
  localparam int unsigned TS1_LSB = 32;
  localparam int unsigned TS2_LSB = 40;
  localparam int unsigned LANE_FIELD_W = 8;
  localparam int unsigned MAX_LANES = 4;
  // ************************************************************
  // Field widths
  // ************************************************************
  localparam int unsigned STATE_W = 5;
  localparam int unsigned RXLP_W = 2;
  localparam int unsigned TXLP_W = 3;
  localparam int unsigned PTYPE_W = 3;
  localparam int unsigned SYM_W = 8;
  // ************************************************************
  // Encodings
  // ************************************************************
  localparam logic [4:0] ST_DETECT_QUIET = 5'h00;
  localparam logic [4:0] ST_L0 = 5'h0f;
  localparam logic [4:0] ST_L0S_TX = 5'h15;
  localparam logic [4:0] ST_LAST = 5'h19;
  localparam logic [1:0] RXLP_INACT = 2'h0;
  localparam logic [2:0] TXLP_INACT = 3'h0;
  localparam logic [3:0] PT_ELEC_IDLE = 4'h0;
  localparam logic [3:0] PT_RX_DETECT = 4'h3;
  localparam logic [3:0] PT_TS1 = 4'h5;
  localparam logic [3:0] PT_TS2 = 4'h7;
  localparam logic [3:0] PT_IDLE_DATA = 4'h9;
  localparam logic [3:0] PT_FTS = 4'hb;
  localparam logic [3:0] PT_IDL = 4'hd;
  localparam logic [3:0] PT_COMPLIANCE = 4'hf;
  localparam logic [7:0] PAD_SYMBOL = 8'hf7;
endpackage

// *** rtl/ltdo_observe.sv ***
// Link training debug observation slice, test bits 367:320
`timescale 1ns/10ps
module ltdo_observe #(
  parameter int unsigned LANES = ltdo_pkg::MAX_LANES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [4:0] train_state_i,
  input wire logic tx_in_l0s_i,
  input wire logic [1:0] rx_lowpower_state_i,
  input wire logic [2:0] tx_lowpower_state_i,
  input wire logic state_timeout_i,
  input wire logic tx_exit_done_i,
  input wire logic pkt_sent_i,
  input wire logic [3:0] pkt_type_i,
  input wire logic [LANES-1:0] rx_detected_i,
  input wire logic [LANES-1:0] force_pad_i,
  input wire logic [LANES-1:0] ts1_seen_i,
  input wire logic [LANES-1:0] ts2_seen_i,
  input wire logic ts_tx_active_i,
  input wire logic [7:0] ts_link_num_i,
  input wire logic [7:0] ts_lane_num_i,
  output logic [ltdo_pkg::LTDO_W-1:0] test_slice_o,
  output logic [LANES-1:0] lane_init_en_o,
  output logic [LANES*8-1:0] ts_link_field_o,
  output logic [LANES*8-1:0] ts_lane_field_o
);
  import ltdo_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  // Spare bits above the supported lanes in each per-lane field
  localparam int unsigned UPPER_W = LANE_FIELD_W - MAX_LANES;
  logic [STATE_W-1:0] state_q, state_d;
  logic [STATE_W-1:0] st_code;
  logic state_change;
  logic [LANES-1:0] ts1_q, ts1_d;
  logic [LANES-1:0] ts2_q, ts2_d;
  logic [LANES-1:0] init_q, init_d;
  logic [LANES*SYM_W-1:0] lfld_q, lfld_d;
  logic [LANES*SYM_W-1:0] nfld_q, nfld_d;
  logic [LTDO_W-1:0] slice_q, slice_d;

  // ************************************************************
  // Training state and received ordered-set flags
  // ************************************************************
  // Shown state code and sticky per-lane flags
  always_comb begin
    st_code = train_state_i;
    if (train_state_i == ST_L0S_TX && !tx_in_l0s_i) begin
      // Receive-only L0s would look like a transmit stall, so it shows as L0
      st_code = ST_L0;
    end
    state_d = st_code;
    // A change of the shown code counts as entering a new state
    state_change = (st_code != state_q);
    // Clear on entry, but a set in the same cycle wins
    ts1_d = (state_change ? '0 : ts1_q) | ts1_seen_i;
    ts2_d = (state_change ? '0 : ts2_q) | ts2_seen_i;
  end

  // State and flag registers; frozen while the enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_DETECT_QUIET;
      ts1_q <= '0;
      ts2_q <= '0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      ts1_q <= ts1_d;
      ts2_q <= ts2_d;
    end
  end

  // ************************************************************
  // Per-lane PAD forcing and initialization enables
  // ************************************************************
  // PAD replaces both numbers on forced lanes while a TS set is built
  always_comb begin
    init_d = ~force_pad_i;
    for (int i = 0; i < LANES; i++) begin
      lfld_d[i*SYM_W +: SYM_W] = (ts_tx_active_i && force_pad_i[i]) ? PAD_SYMBOL : ts_link_num_i;
      nfld_d[i*SYM_W +: SYM_W] = (ts_tx_active_i && force_pad_i[i]) ? PAD_SYMBOL : ts_lane_num_i;
    end
  end

  // Lane registers; after reset no lane is enabled until the first enabled edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_q <= '0;
      lfld_q <= '0;
      nfld_q <= '0;
    end else if (clk_en_i) begin
      init_q <= init_d;
      lfld_q <= lfld_d;
      nfld_q <= nfld_d;
    end
  end

  // ************************************************************
  // Observation slice
  // ************************************************************
  // Assemble the slice; gaps and spare lane bits stay zero
  always_comb begin
    slice_d = '0;
    slice_d[STATE_LSB +: STATE_W] = st_code;
    slice_d[RXLP_LSB +: RXLP_W] = rx_lowpower_state_i;
    slice_d[TXLP_LSB +: TXLP_W] = tx_lowpower_state_i;
    slice_d[TMO_BIT] = state_timeout_i;
    slice_d[EXIT_BIT] = tx_exit_done_i;
    // A held request alternates rather than stretching the pulse
    slice_d[ACK_BIT] = pkt_sent_i && !slice_q[ACK_BIT];
    // Field is three bits wide; the top code bit is dropped
    slice_d[PTYPE_LSB +: PTYPE_W] = pkt_type_i[PTYPE_W-1:0];
    slice_d[DET_LSB +: LANES] = rx_detected_i;
    slice_d[PAD_LSB +: LANES] = force_pad_i;
    slice_d[TS1_LSB +: LANES] = ts1_d;
    slice_d[TS2_LSB +: LANES] = ts2_d;
  end

  // Slice register; nothing reads it back into the link
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slice_q <= '0;
    end else if (clk_en_i) begin
      slice_q <= slice_d;
    end
  end

  // Every output straight from its register
  assign test_slice_o = slice_q;
  assign lane_init_en_o = init_q;
  assign ts_link_field_o = lfld_q;
  assign ts_lane_field_o = nfld_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  // Acknowledge pulse
  a_ack_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    slice_q[ACK_BIT] && clk_en_i |=> !slice_q[ACK_BIT])
    else $error("ack longer than one cycle");
  a_ack_rises: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && pkt_sent_i && !slice_q[ACK_BIT] |=> slice_q[ACK_BIT])
    else $error("ack missing after send");
  // State code
  a_l0s_tx_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && train_state_i == ST_L0S_TX && !tx_in_l0s_i |=> slice_q[STATE_LSB +: STATE_W] == ST_L0)
    else $error("L0s code without tx L0s");
  a_l0s_tx_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && train_state_i == ST_L0S_TX && tx_in_l0s_i |=> slice_q[STATE_LSB +: STATE_W] == ST_L0S_TX)
    else $error("tx L0s code lost");
  a_state_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && train_state_i != ST_L0S_TX |=> slice_q[STATE_LSB +: STATE_W] == $past(train_state_i))
    else $error("state code mismatch");
  // Plain field mapping
  a_rxlp_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[RXLP_LSB +: RXLP_W] == $past(rx_lowpower_state_i))
    else $error("rx low-power field wrong");
  a_txlp_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[TXLP_LSB +: TXLP_W] == $past(tx_lowpower_state_i))
    else $error("tx low-power field wrong");
  a_timeout_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[TMO_BIT] == $past(state_timeout_i))
    else $error("timeout flag wrong");
  a_exit_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[EXIT_BIT] == $past(tx_exit_done_i))
    else $error("exit flag wrong");
  a_ptype_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[PTYPE_LSB +: PTYPE_W] == $past(pkt_type_i[PTYPE_W-1:0]))
    else $error("packet type field wrong");
  a_detect_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> slice_q[DET_LSB +: LANES] == $past(rx_detected_i))
    else $error("detect flags wrong");
  // Per-lane fields
  a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    slice_q[DET_LSB+MAX_LANES +: UPPER_W] == '0 && slice_q[PAD_LSB+MAX_LANES +: UPPER_W] == '0 &&
    slice_q[TS1_LSB+MAX_LANES +: UPPER_W] == '0 && slice_q[TS2_LSB+MAX_LANES +: UPPER_W] == '0)
    else $error("upper lane bits set");
  a_ts_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_change && ts1_seen_i == '0 |=> ts1_q == '0)
    else $error("ts1 flags not cleared");
  a_ts1_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && ts1_seen_i[0] |=> slice_q[TS1_LSB])
    else $error("ts1 flag not set");
  a_ts2_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && ts2_seen_i[0] |=> slice_q[TS2_LSB])
    else $error("ts2 flag not set");
  a_ts2_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ts2_q[0] && clk_en_i && !state_change |=> ts2_q[0])
    else $error("ts2 flag lost");
  // Lane control
  a_pad_excl: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && force_pad_i[0] |=> !lane_init_en_o[0])
    else $error("pad lane initialised");
  a_lane_enabled: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && !force_pad_i[0] |=> lane_init_en_o[0])
    else $error("normal lane not enabled");
  a_pad_field: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && ts_tx_active_i && force_pad_i[0] |=> ts_link_field_o[SYM_W-1:0] == PAD_SYMBOL)
    else $error("pad not forced");
  a_pad_lane_num: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && ts_tx_active_i && force_pad_i[0] |=> ts_lane_field_o[SYM_W-1:0] == PAD_SYMBOL)
    else $error("pad not forced in lane field");
  // Freeze
  a_freeze_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> $stable(slice_q))
    else $error("slice moved while frozen");
endmodule // ltdo_observe

// *** sim/ltdo_monitor.sv ***
// Monitor model: on-chip debug logic sampling the observation slice
`timescale 1ns/10ps
module ltdo_monitor (
  input wire logic ref_clk_i,
  input wire logic [ltdo_pkg::LTDO_W-1:0] slice_i,
  output logic [ltdo_pkg::LTDO_W-1:0] seen_o
);
  import ltdo_pkg::*;
  // Pure sampler; it never feeds back, so the slice cannot steer the link
  always_ff @(posedge ref_clk_i) begin
    seen_o <= slice_i;
  end
endmodule // ltdo_monitor

// *** sim/tb_ltdo_observe.sv ***
// Self-checking bench for the link training observation slice
`timescale 1ns/10ps
module tb_ltdo_observe;
  import ltdo_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, en = 0, txl = 0, tmo = 0, ex = 0, snt = 0, act = 1;
  logic [4:0] st = 0;
  logic [1:0] rxl = 0;
  logic [2:0] txs = 0;
  logic [3:0] pt = 0, det = 0, pad = 0, t1 = 0, t2 = 0, ie, iee = 0;
  logic [7:0] ln = 0, la = 0;
  logic [31:0] lf, lnf, elf = 0, enf = 0;
  logic [47:0] sl, seen, e = 0, pe = 0;
  int failures = 0, checked = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  ltdo_observe dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(en), .train_state_i(st),
    .tx_in_l0s_i(txl), .rx_lowpower_state_i(rxl), .tx_lowpower_state_i(txs), .state_timeout_i(tmo),
    .tx_exit_done_i(ex), .pkt_sent_i(snt), .pkt_type_i(pt), .rx_detected_i(det), .force_pad_i(pad),
    .ts1_seen_i(t1), .ts2_seen_i(t2), .ts_tx_active_i(act), .ts_link_num_i(ln), .ts_lane_num_i(la),
    .test_slice_o(sl), .lane_init_en_o(ie), .ts_link_field_o(lf), .ts_lane_field_o(lnf));
  ltdo_monitor mon_u (.ref_clk_i(ref_clk_i), .slice_i(sl), .seen_o(seen));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Next slice from present inputs; upper lane nibbles stay zero
  function automatic logic [47:0] nxt(input logic [47:0] o);
    logic [4:0] s;
    logic [47:0] n;
    s = (st == ST_L0S_TX && !txl) ? ST_L0 : st;
    n = '0;
    n[4:0] = s;
    n[6:5] = rxl;
    n[9:7] = txs;
    n[10] = tmo;
    n[11] = ex;
    n[12] = snt & ~o[12];
    n[15:13] = pt[2:0];
    n[19:16] = det;
    n[27:24] = pad;
    n[35:32] = (s != o[4:0] ? 4'h0 : o[35:32]) | t1;
    n[43:40] = (s != o[4:0] ? 4'h0 : o[43:40]) | t2;
    return n;
  endfunction
  // Expected TS number fields: PAD on forced lanes while a set is built
  function automatic logic [31:0] fld(input logic [7:0] num);
    logic [31:0] f;
    for (int k = 0; k < 4; k++) f[k*8 +: 8] = (act && pad[k]) ? PAD_SYMBOL : num;
    return f;
  endfunction
  // Corner cases first: held packet strobe, L0s code with both tx states
  initial begin
    void'($urandom(32'h8b360f90));
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1;
    for (int i = 0; i < 400; i++) begin
      @(negedge ref_clk_i);
      chk(sl, e);
      chk(seen, pe);
      pe = e;
      chk({44'h0, ie}, {44'h0, iee});
      chk({16'h0, lf}, {16'h0, elf});
      chk({16'h0, lnf}, {16'h0, enf});
      en = (i < 12) || ($urandom_range(7) != 0);
      if (i < 24 || $urandom_range(7) == 0) st = (i < 24) ? ST_L0S_TX : 5'($urandom_range(25));
      snt = (i < 12) ? 1'b1 : 1'($urandom);
      {txl, rxl, txs, tmo, ex, pt} = 12'($urandom);
      {act, det, pad, ln, la} = 25'($urandom);
      t1 = 4'($urandom & $urandom);
      t2 = 4'($urandom & $urandom);
      if (en) begin
        e = nxt(e);
        iee = ~pad;
        elf = fld(ln);
        enf = fld(la);
      end
      // Mid-run reset: everything must drop to zero at once
      if (i == 200) begin
        rst_n_i = 0;
        e = '0;
        pe = '0;
        iee = '0;
        elf = '0;
        enf = '0;
      end else rst_n_i = 1;
    end
    test_done();
  end
endmodule // tb_ltdo_observe
